// ===== src/keycmd_core.sv
/*
 * Command execution for the counter, MAC-verify and key-derivation commands.
 * Assumes slot and key configuration, keys, the temporary register and the
 * serial number come from storage on the same clock, keys read
 * combinationally by o_key_idx, and an external hash engine takes bytes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "keycmd_defines.svh"

module keycmd_core
	import keycmd_pkg::*;
(
	// Clock and reset.
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	// Command in and reply out.
	input wire logic i_cmd_valid,
	input wire cmd_s i_cmd,
	output logic o_cmd_ready,
	output logic o_resp_valid,
	output logic [2:0] o_resp_len,
	output logic [31:0] o_resp_data,
	// Watchdog warning from the sleep logic.
	input wire logic i_wdt_low,
	// Command data fields.
	input wire logic [255:0] i_challenge_input,
	input wire logic [255:0] i_response_input,
	input wire logic [103:0] i_extra_message_bytes,
	input wire logic [255:0] i_input_mac,
	// Configuration and lock state.
	input wire logic [15:0][15:0] i_slot_config_word,
	input wire logic [15:0][15:0] i_key_config_word,
	input wire logic [15:0] i_per_slot_lock,
	input wire logic i_config_locked,
	input wire logic [71:0] i_serial_number_bytes,
	// Temporary register and authorization state.
	input wire logic [255:0] i_temporary_register,
	input wire logic i_temp_valid,
	input wire logic i_nonce_source_flag,
	input wire logic i_auth_valid,
	input wire logic [3:0] i_authorizing_key_index,
	// Key storage read.
	output logic [3:0] o_key_idx,
	input wire logic [255:0] i_key_value,
	// Hash engine.
	output logic o_msg_valid,
	output logic o_msg_last,
	output logic [7:0] o_msg_byte,
	input wire logic i_msg_ready,
	input wire logic i_digest_valid,
	input wire logic [255:0] i_digest,
	// Slot write of a derived key.
	output logic o_slot_wr_valid,
	output logic [3:0] o_slot_wr_idx,
	output logic [255:0] o_slot_wr_data,
	// Counter storage.
	input wire logic i_ctr_load,
	input wire logic [20:0] i_ctr0_init,
	input wire logic [20:0] i_ctr1_init,
	output logic o_ctr_wr_valid,
	output logic o_ctr_wr_id,
	output logic [20:0] o_ctr_wr_val,
	// Key use limiting by counter zero.
	input wire logic i_key_use,
	input wire logic i_key_use_limited,
	output logic o_key_use_refused
);

	state_s r;
	state_s n;

	// Decoded fields of the derivation target, its parent and its source.
	logic [3:0] tgt;
	logic [15:0] tsc;
	logic [15:0] tkc;
	logic [3:0] par;
	logic [15:0] psc;
	logic [15:0] pkc;
	logic create;
	logic mac_req;
	logic [3:0] src;
	logic [15:0] skc;
	logic parent_used;
	logic tgt_auth_ok;
	logic par_auth_ok;
	logic [767:0] msg;
	logic [6:0] len;

	// Target, parent and source slot lookups for derivation.
	assign tgt = r.cmd.second_parameter[3:0];
	assign tsc = i_slot_config_word[tgt];
	assign tkc = i_key_config_word[tgt];
	assign par = tsc[`SC_WK_LSB +: 4];
	assign psc = i_slot_config_word[par];
	assign pkc = i_key_config_word[par];
	assign create = tsc[`SC_CREATE];
	assign mac_req = tsc[`SC_MAC_REQ];
	assign src = create ? par : tgt;
	assign skc = i_key_config_word[src];
	assign parent_used = create | mac_req;

	// Authorization is met when not required or done with the named key.
	assign tgt_auth_ok = !tkc[`KC_REQ_AUTH] ||
		(i_auth_valid && i_authorizing_key_index == tkc[`KC_AUTH_LSB +: 4]);
	assign par_auth_ok = !pkc[`KC_REQ_AUTH] ||
		(i_auth_valid && i_authorizing_key_index == pkc[`KC_AUTH_LSB +: 4]);

	// Hash message of the current job, byte zero in the low bits.
	always_comb begin
		msg = '0;
		len = `LEN_DK;
		case (r.kind)
			K_MV: begin
				len = `LEN_MV;
				msg[703:0] = {i_extra_message_bytes[103:88],
					i_serial_number_bytes[15:0],
					i_extra_message_bytes[87:56],
					i_serial_number_bytes[71:64],
					i_extra_message_bytes[55:32],
					{8{8'h00}},
					i_extra_message_bytes[31:0],
					r.cmd.mode[`MODE_TEMP_CHAL] ? i_temporary_register : i_challenge_input,
					r.cmd.mode[`MODE_TEMP_KEY] ? i_temporary_register : i_key_value};
			end
			K_IM: begin
				len = `LEN_IM;
				msg[311:0] = {i_serial_number_bytes[15:0], i_serial_number_bytes[71:64],
					r.cmd.second_parameter, r.cmd.mode, r.cmd.opcode, i_key_value};
			end
			default: begin
				msg = {i_temporary_register, {25{8'h00}},
					i_serial_number_bytes[15:0], i_serial_number_bytes[71:64],
					r.cmd.second_parameter, r.cmd.mode, r.cmd.opcode, i_key_value};
			end
		endcase
	end

	// Next-state logic for the whole block.
	always_comb begin
		logic fin;
		logic [2:0] flen;
		logic [31:0] fdata;
		logic [20:0] val;
		fin = 1'b0;
		flen = `RLEN_BYTE;
		fdata = '0;
		val = '0;
		n = r;
		n.resp_valid = 1'b0;
		n.wr_valid = 1'b0;
		n.ctr_wr_valid = 1'b0;
		n.refused = 1'b0;

		// Counter values restored from storage.
		if (i_ctr_load) begin
			n.ctr0 = i_ctr0_init;
			n.ctr1 = i_ctr1_init;
		end

		// Each use of a limited key advances counter zero or is refused.
		if (i_key_use && i_key_use_limited) begin
			if (n.ctr0 == `CTR_MAX) begin
				n.refused = 1'b1;
			end else begin
				n.ctr0 = n.ctr0 + 21'h000001;
				n.ctr_wr_valid = 1'b1;
				n.ctr_wr_id = 1'b0;
				n.ctr_wr_val = n.ctr0;
			end
		end

		case (r.st)
			ST_IDLE: begin
				if (i_cmd_valid) begin
					n.cmd = i_cmd;
					n.ready = 1'b0;
					if (i_wdt_low) begin
						fin = 1'b1;
						fdata[7:0] = `RC_WDT;
					end else begin
						n.st = ST_CHECK;
					end
				end
			end

			ST_CHECK: begin
				if (r.cmd.opcode == `OP_COUNTER) begin
					fin = 1'b1;
					if ((r.cmd.mode & `MODE_CTR_RSVD) != 8'h00 ||
						r.cmd.second_parameter > `CTR_ID_MAX) begin
						fdata[7:0] = `RC_PARSE;
					end else if (n.ctr_wr_valid) begin
						// A key use writes counter zero back now; answer a cycle later.
						fin = 1'b0;
					end else begin
						val = r.cmd.second_parameter[0] ? n.ctr1 : n.ctr0;
						if (r.cmd.mode[`MODE_INC] && val == `CTR_MAX) begin
							fdata[7:0] = `RC_EXEC;
						end else begin
							if (r.cmd.mode[`MODE_INC]) begin
								val = val + 21'h000001;
								if (r.cmd.second_parameter[0]) begin
									n.ctr1 = val;
								end else begin
									n.ctr0 = val;
								end
								n.ctr_wr_valid = 1'b1;
								n.ctr_wr_id = r.cmd.second_parameter[0];
								n.ctr_wr_val = val;
							end
							flen = `RLEN_WORD;
							fdata = {11'h000, val};
						end
					end
				end else if (r.cmd.opcode == `OP_MAC_VERIFY) begin
					if ((r.cmd.mode & `MODE_MV_RSVD) != 8'h00) begin
						fin = 1'b1;
						fdata[7:0] = `RC_PARSE;
					end else if ((r.cmd.mode[`MODE_TEMP_KEY] || r.cmd.mode[`MODE_TEMP_CHAL]) &&
						(!i_temp_valid || r.cmd.mode[`MODE_SRC] != i_nonce_source_flag)) begin
						fin = 1'b1;
						fdata[7:0] = `RC_EXEC;
					end else begin
						n.kind = K_MV;
						n.key_idx = tgt;
						n.idx = '0;
						n.st = ST_HASH;
					end
				end else if (r.cmd.opcode == `OP_DERIVE) begin
					fin = 1'b1;
					if ((r.cmd.mode & `MODE_DK_RSVD) != 8'h00) begin
						fdata[7:0] = `RC_PARSE;
					end else if (!tsc[`SC_DERIVE_OK]) begin
						fdata[7:0] = `RC_EXEC;
					end else if (tkc[`KC_PRIVATE] || !i_config_locked || i_per_slot_lock[tgt]) begin
						fdata[7:0] = `RC_EXEC;
					end else if (!i_temp_valid || (skc[`KC_REQ_RANDOM] && i_nonce_source_flag)) begin
						fdata[7:0] = `RC_EXEC;
					end else if (r.cmd.mode[`MODE_SRC] != i_nonce_source_flag) begin
						fdata[7:0] = `RC_EXEC;
					end else if (!create && !tgt_auth_ok) begin
						fdata[7:0] = `RC_EXEC;
					end else if (parent_used && !par_auth_ok) begin
						fdata[7:0] = `RC_EXEC;
					end else if (parent_used && psc[`SC_USE_LIMITED] && n.ctr0 == `CTR_MAX) begin
						fdata[7:0] = `RC_EXEC;
					end else begin
						fin = 1'b0;
						n.kind = mac_req ? K_IM : K_DK;
						n.key_idx = mac_req ? par : src;
						n.idx = '0;
						n.st = ST_HASH;
					end
				end else begin
					fin = 1'b1;
					fdata[7:0] = `RC_PARSE;
				end
			end

			ST_HASH: begin
				// The first byte waits a cycle so the key read has settled.
				if (!r.msg_valid) begin
					n.msg_valid = 1'b1;
					n.msg_byte = msg[{r.idx, 3'h0} +: 8];
					n.msg_last = r.idx == len - 7'h01;
				end else if (i_msg_ready) begin
					if (r.msg_last) begin
						n.msg_valid = 1'b0;
						n.msg_last = 1'b0;
						n.st = ST_WAIT;
					end else begin
						n.idx = r.idx + 7'h01;
						n.msg_byte = msg[{n.idx, 3'h0} +: 8];
						n.msg_last = n.idx == len - 7'h01;
					end
				end
			end

			ST_WAIT: begin
				if (i_digest_valid) begin
					if (r.kind == K_MV) begin
						fin = 1'b1;
						fdata[7:0] = (i_digest == i_response_input) ? `RC_OK : `RC_MISMATCH;
					end else if (r.kind == K_IM) begin
						if (i_digest == i_input_mac) begin
							n.kind = K_DK;
							n.key_idx = src;
							n.idx = '0;
							n.st = ST_HASH;
						end else begin
							fin = 1'b1;
							fdata[7:0] = `RC_EXEC;
						end
					end else begin
						fin = 1'b1;
						fdata[7:0] = `RC_OK;
						n.wr_valid = 1'b1;
						n.wr_idx = tgt;
						n.wr_data = i_digest;
					end
				end
			end

			default: begin
				n.st = ST_IDLE;
			end
		endcase

		// Any finished command returns its reply and frees the block.
		if (fin) begin
			n.resp_valid = 1'b1;
			n.resp_len = flen;
			n.resp_data = fdata;
			n.ready = 1'b1;
			n.st = ST_IDLE;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.kind <= K_MV;
			r.ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register.
	assign o_cmd_ready = r.ready;
	assign o_resp_valid = r.resp_valid;
	assign o_resp_len = r.resp_len;
	assign o_resp_data = r.resp_data;
	assign o_key_idx = r.key_idx;
	assign o_msg_valid = r.msg_valid;
	assign o_msg_last = r.msg_last;
	assign o_msg_byte = r.msg_byte;
	assign o_slot_wr_valid = r.wr_valid;
	assign o_slot_wr_idx = r.wr_idx;
	assign o_slot_wr_data = r.wr_data;
	assign o_ctr_wr_valid = r.ctr_wr_valid;
	assign o_ctr_wr_id = r.ctr_wr_id;
	assign o_ctr_wr_val = r.ctr_wr_val;
	assign o_key_use_refused = r.refused;

endmodule // keycmd_core

`default_nettype wire

// ===== src/keycmd_defines.svh
/*
 * Constants of the counter, MAC-verify and key-derivation command block:
 * opcodes, reply codes, mode fields, configuration bit positions, limits.
 * Assumes it is included by bare name from the package and the design.
 */
// Functional notes
// - MAC verify replies zero on match, one otherwise
// - MAC verify hash message in fixed byte order
// - Counters stop at maximum, overflow gives error
// - Count committed with reply, never lost (counter write issued in the same cycle as the reply)
// - Only counter zero limits key use
// - Counter opcode, mode bit zero selects increment
// - Counter identifier above one is parse error
// - Counter replies four bytes, failed increment one
// - Derivation needs target bit thirteen set
// - Refuse private key, unlocked config, locked slot
// - Bit twelve chooses target or parent source
// - Valid nonce needed, random when source demands
// - Derive opcode, mode bit two matches flag
// - Target bit fifteen demands verified input MAC
// - Roll needs prior target authorization if required
// - Create or MAC needs parent authorization
// - Limited parent refused when counter zero exhausted
// - Successful derivation replies single zero byte
// - Derived key hashes source, params, serial, nonce
// - Watchdog near expiry refuses before starting
`ifndef KEYCMD_DEFINES_SVH
`define KEYCMD_DEFINES_SVH

`define OP_COUNTER 8'h24
`define OP_MAC_VERIFY 8'h28
`define OP_DERIVE 8'h1c

`define RC_OK 8'h00
`define RC_MISMATCH 8'h01
`define RC_PARSE 8'h03
`define RC_EXEC 8'h0f
`define RC_WDT 8'hee

`define CTR_MAX 21'h1fffff
`define CTR_ID_MAX 16'h0001
`define RLEN_BYTE 3'h1
`define RLEN_WORD 3'h4

`define MODE_CTR_RSVD 8'hfe
`define MODE_MV_RSVD 8'hf8
`define MODE_DK_RSVD 8'hfb
`define MODE_INC 0
`define MODE_TEMP_CHAL 0
`define MODE_TEMP_KEY 1
`define MODE_SRC 2

`define SC_USE_LIMITED 5
`define SC_WK_LSB 8
`define SC_CREATE 12
`define SC_DERIVE_OK 13
`define SC_MAC_REQ 15
`define KC_PRIVATE 0
`define KC_REQ_RANDOM 6
`define KC_REQ_AUTH 7
`define KC_AUTH_LSB 8

`define LEN_MV 7'h58
`define LEN_DK 7'h60
`define LEN_IM 7'h27

`endif

// ===== src/keycmd_pkg.sv
/*
 * Types shared by the command block: command packet, states, hash jobs and
 * the packed state record. Assumes the defines header is on the include path.
 */
`include "keycmd_defines.svh"

package keycmd_pkg;

	// Command packet as handed over by the transport.
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] mode;
		logic [15:0] second_parameter;
	} cmd_s;

	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_HASH, ST_WAIT} state_e;

	// Which message is being streamed to the hash engine.
	typedef enum logic [1:0] {K_MV, K_IM, K_DK} kind_e;

	// Whole state of the command block.
	typedef struct packed {
		state_e st;
		kind_e kind;
		cmd_s cmd;
		logic ready;
		logic [6:0] idx;
		logic [3:0] key_idx;
		logic [20:0] ctr0;
		logic [20:0] ctr1;
		logic msg_valid;
		logic msg_last;
		logic [7:0] msg_byte;
		logic resp_valid;
		logic [2:0] resp_len;
		logic [31:0] resp_data;
		logic wr_valid;
		logic [3:0] wr_idx;
		logic [255:0] wr_data;
		logic ctr_wr_valid;
		logic ctr_wr_id;
		logic [20:0] ctr_wr_val;
		logic refused;
	} state_s;

endpackage

// ===== verification/keycmd_assertions.sv
/* Port checker for the command block, bound to keycmd_core below.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
`include "keycmd_defines.svh"
module keycmd_assertions
	import keycmd_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_cmd_valid,
	input wire cmd_s i_cmd,
	input wire logic i_wdt_low,
	input wire logic [15:0][15:0] i_slot_config_word,
	input wire logic [15:0][15:0] i_key_config_word,
	input wire logic [15:0] i_per_slot_lock,
	input wire logic i_config_locked,
	input wire logic i_key_use,
	input wire logic i_key_use_limited,
	// Outputs under watch.
	input wire logic o_cmd_ready,
	input wire logic o_resp_valid,
	input wire logic [2:0] o_resp_len,
	input wire logic [31:0] o_resp_data,
	input wire logic o_slot_wr_valid,
	input wire logic o_ctr_wr_valid,
	input wire logic o_ctr_wr_id,
	input wire logic [20:0] o_ctr_wr_val,
	input wire logic o_key_use_refused
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	logic [3:0] tgt;
	logic dk;
	logic use_lim;
	// Target slot, a clean derive packet and a limited key use.
	assign tgt = i_cmd.second_parameter[3:0];
	assign dk = i_cmd.opcode == `OP_DERIVE && i_cmd.mode == 8'h00 && i_cmd.second_parameter[15:4] == 12'h000;
	assign use_lim = i_key_use && i_key_use_limited;
	// A take with watchdog time left, and the two-cycle error replies.
	sequence s_take;
		o_cmd_ready && i_cmd_valid && !i_wdt_low;
	endsequence
	sequence s_parse;
		##2 o_resp_valid && o_resp_data == 32'h00000003;
	endsequence
	sequence s_fail;
		##2 o_resp_valid && o_resp_len == 3'h1 && o_resp_data[7:0] != 8'h00;
	endsequence
	a_wdt_quick_reply: assert property (o_cmd_ready && i_cmd_valid && i_wdt_low
		|=> o_resp_valid && o_resp_data == 32'h000000ee) else $error("watchdog reply wrong");
	a_ctr_id_parse: assert property (s_take ##0 i_cmd.opcode == `OP_COUNTER
		&& i_cmd.second_parameter > 16'h0001 |-> s_parse) else $error("counter id not refused");
	a_dk_bit13: assert property (s_take ##0 dk && !i_slot_config_word[tgt][13]
		|-> s_fail) else $error("derive without permission");
	a_dk_lock_refuse: assert property (s_take ##0 dk && (i_key_config_word[tgt][0]
		|| !i_config_locked || i_per_slot_lock[tgt]) |-> s_fail) else $error("derive not refused");
	a_dk_mode_parse: assert property (s_take ##0 i_cmd.opcode == `OP_DERIVE
		&& (i_cmd.mode & 8'hfb) != 8'h00 |-> s_parse) else $error("derive mode not refused");
	a_exec_no_write: assert property (o_resp_valid && o_resp_len == 3'h1 && o_resp_data[7:0] == 8'h0f
		|-> !o_slot_wr_valid && (!o_ctr_wr_valid || ($past(use_lim) && !o_ctr_wr_id)))
		else $error("write after error");
	a_ctr_reply_word: assert property (o_resp_valid && o_ctr_wr_valid && !$past(use_lim)
		|-> o_resp_len == 3'h4 && o_resp_data == {11'h000, o_ctr_wr_val}) else $error("count reply");
	a_slot_wr_ok: assert property (o_slot_wr_valid
		|-> o_resp_valid && o_resp_len == 3'h1 && o_resp_data == 32'h0) else $error("derive reply");
	a_use_refused: assert property (o_key_use_refused
		|-> $past(use_lim) && !(o_ctr_wr_valid && !o_ctr_wr_id)) else $error("bad use refusal");
endmodule // keycmd_assertions
bind keycmd_core keycmd_assertions u_chk (.*);
`default_nettype wire

// ===== verification/hash_model.sv
/* Hash engine model: takes bytes, records them, pulses a fixed digest.
   Assumes the core's byte handshake; stalls every other cycle when slow. */
`timescale 1ns/10ps
`default_nettype none
module hash_model #(
	parameter logic [255:0] DIG = {8{32'h5a3c96e1}}
) (
	// Clock, reset and pace.
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_slow,
	// Byte stream and digest.
	input wire logic i_msg_valid,
	input wire logic i_msg_last,
	input wire logic [7:0] i_msg_byte,
	output logic o_msg_ready,
	output logic o_digest_valid,
	output logic [255:0] o_digest
);
	logic [7:0] msg [0:127];
	int n;
	int n_last;
	logic tog;
	// Outside its pulse the digest shows a different pattern.
	assign o_msg_ready = !i_slow || tog;
	assign o_digest = o_digest_valid ? DIG : ~DIG;
	// Record accepted bytes and answer one cycle after the last.
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			n <= 0;
			tog <= 1'b0;
			o_digest_valid <= 1'b0;
		end else begin
			tog <= !tog;
			o_digest_valid <= i_msg_valid && o_msg_ready && i_msg_last;
			if (i_msg_valid && o_msg_ready) begin
				msg[n[6:0]] <= i_msg_byte;
				n <= i_msg_last ? 0 : n + 1;
				if (i_msg_last) n_last <= n + 1;
			end
		end
	end
endmodule // hash_model
`default_nettype wire

// ===== verification/tb_top.sv
/* Self-checking bench for keycmd_core with a hash engine model.
   Assumes the design sources and the checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`include "keycmd_defines.svh"
module tb_top;
	import keycmd_pkg::*;
	localparam logic [255:0] DIG = {8{32'h5a3c96e1}};
	logic i_ref_clk, i_rstn, i_cmd_valid, o_cmd_ready, o_resp_valid, i_wdt_low, i_slow;
	logic i_config_locked, i_temp_valid, i_nonce_source_flag, i_auth_valid, i_msg_ready;
	logic o_msg_valid, o_msg_last, i_digest_valid, o_slot_wr_valid, i_ctr_load;
	logic o_ctr_wr_valid, o_ctr_wr_id, i_key_use, i_key_use_limited, o_key_use_refused;
	cmd_s i_cmd;
	logic [2:0] o_resp_len, r_len;
	logic [31:0] o_resp_data, r_data, r_wd, seed, tmp, e;
	logic [255:0] i_challenge_input, i_response_input, i_input_mac, i_temporary_register;
	logic [255:0] i_key_value, i_digest, o_slot_wr_data;
	logic [103:0] i_extra_message_bytes;
	logic [15:0][15:0] i_slot_config_word, i_key_config_word;
	logic [15:0] i_per_slot_lock;
	logic [71:0] i_serial_number_bytes;
	logic [3:0] i_authorizing_key_index, o_key_idx, o_slot_wr_idx, r_wi;
	logic [7:0] o_msg_byte;
	logic [20:0] i_ctr0_init, i_ctr1_init, o_ctr_wr_val, ctr [2];
	logic r_wr, r_cw, r_ci, id, inc;
	int n_fail = 0, samples_checked = 0, cycles = 0;
	keycmd_core DUT (.*);
	hash_model HM (.i_ref_clk, .i_rstn, .i_slow, .i_msg_valid(o_msg_valid),
		.i_msg_last(o_msg_last), .i_msg_byte(o_msg_byte), .o_msg_ready(i_msg_ready),
		.o_digest_valid(i_digest_valid), .o_digest(i_digest));
	// Key storage: every byte of a slot's key is its index.
	assign i_key_value = {32{4'h0, o_key_idx}};
	// Repeatable xorshift source.
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected byte i of the derive message for slot 2.
	function automatic logic [7:0] exp_dk(int i);
		logic [55:0] mid;
		mid = {8'h1c, 8'h00, 8'h02, 8'h00, i_serial_number_bytes[71:64],
			i_serial_number_bytes[7:0], i_serial_number_bytes[15:8]};
		if (i < 32) return 8'h02;
		if (i < 39) return mid[8*(38-i)+:8];
		if (i < 64) return 8'h00;
		return i_temporary_register[8*(i-64)+:8];
	endfunction
	// Expected counter reply, updating the bench's copy.
	function automatic logic [31:0] exp_ctr(logic c, logic up);
		if (up && ctr[c] == 21'h1fffff) return 32'h0000000f;
		if (up) ctr[c] = ctr[c] + 21'h1;
		return {11'h000, ctr[c]};
	endfunction
	// Compare one value and count it.
	task chk(string nm, logic [31:0] x, logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask
	// Report and end the run.
	task tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Offer one command and capture its reply cycle.
	task run(logic [7:0] op, logic [7:0] md, logic [15:0] p2);
		int n;
		@(negedge i_ref_clk);
		i_cmd = '{op, md, p2};
		i_cmd_valid = 1'b1;
		@(negedge i_ref_clk);
		i_cmd_valid = 1'b0;
		chk("busy", i_wdt_low, o_cmd_ready);
		n = 0;
		while (!o_resp_valid && n < 3000) begin
			@(negedge i_ref_clk);
			n++;
		end
		if (n >= 3000) n_fail++;
		{r_len, r_data, r_wr, r_cw, r_wd, r_wi, r_ci} = {o_resp_len, o_resp_data,
			o_slot_wr_valid, o_ctr_wr_valid, o_slot_wr_data[31:0], o_slot_wr_idx, o_ctr_wr_id};
		chk("ready", 32'h1, o_cmd_ready);
	endtask
	// Load both counters, then report one key use.
	task load(logic [20:0] c0, logic [20:0] c1);
		@(negedge i_ref_clk);
		{i_ctr0_init, i_ctr1_init, ctr[0], ctr[1], i_ctr_load} = {c0, c1, c0, c1, 1'b1};
		@(negedge i_ref_clk);
		i_ctr_load = 1'b0;
	endtask
	task key_use();
		@(negedge i_ref_clk);
		i_key_use = 1'b1;
		@(negedge i_ref_clk);
		i_key_use = 1'b0;
	endtask
	// Clock and a hang limit.
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// Main sequence.
	initial begin
		seed = 32'had64;
		{i_rstn, i_cmd_valid, i_cmd, i_wdt_low, i_key_use, i_ctr_load, i_slow} = '0;
		{i_ctr0_init, i_ctr1_init, i_auth_valid, i_authorizing_key_index, i_input_mac} = '0;
		{i_key_use_limited, i_config_locked, i_temp_valid, i_nonce_source_flag} = 4'he;
		i_slot_config_word = '0;
		i_key_config_word = '0;
		i_slot_config_word[2] = 16'h2000;
		i_slot_config_word[4] = 16'h2000;
		i_slot_config_word[5] = 16'h2000;
		i_key_config_word[4] = 16'h0001;
		i_per_slot_lock = 16'h0020;
		i_serial_number_bytes = 72'h99000000000000c3a5;
		i_challenge_input = {8{rnd()}};
		i_extra_message_bytes = 104'({4{rnd()}});
		i_temporary_register = {8{rnd()}};
		i_response_input = DIG;
		repeat (5) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		i_rstn = 1'b1;
		load(21'h1ffffd, 21'(rnd()));
		for (int k = 0; k < 24; k++) begin
			tmp = rnd();
			id = (k < 4) ? 1'b0 : tmp[0];
			inc = (k < 4) ? 1'b1 : tmp[1];
			e = exp_ctr(id, inc);
			run(`OP_COUNTER, {7'h00, inc}, {15'h0000, id});
			chk("ctr reply", e, r_data);
			chk("ctr len", (e == 32'hf) ? 32'h1 : 32'h4, r_len);
			chk("ctr write", {inc && e != 32'hf, id}, {r_cw, r_cw ? r_ci : id});
		end
		run(`OP_COUNTER, 8'h00, 16'h0002);
		chk("ctr id", 32'h3, r_data);
		load(21'h1fffff, 21'h0);
		key_use();
		chk("use refused", 32'h1, o_key_use_refused);
		load(21'h5, 21'h0);
		key_use();
		chk("use count", {1'b1, 21'h6}, {o_ctr_wr_valid, o_ctr_wr_val});
		i_wdt_low = 1'b1;
		run(`OP_DERIVE, 8'h00, 16'h0002);
		chk("watchdog", 32'hee, r_data);
		i_wdt_low = 1'b0;
		for (int s = 3; s < 7; s++) begin
			i_config_locked = (s != 6);
			run(`OP_DERIVE, 8'h00, (s == 6) ? 16'h0002 : 16'(s));
			chk("derive refused", 32'h1, {r_wr, r_data != 32'h0});
		end
		i_config_locked = 1'b1;
		i_slow = 1'b1;
		run(`OP_DERIVE, 8'h00, 16'h0002);
		chk("derive reply", {1'b1, 32'h0}, {r_wr, r_data});
		chk("derive key", DIG[31:0], r_wd);
		chk("derive slot", 32'h2, r_wi);
		chk("derive length", 32'd96, HM.n_last);
		for (int i = 0; i < 96; i++) chk("derive byte", exp_dk(i), HM.msg[i]);
		i_slow = 1'b0;
		run(`OP_MAC_VERIFY, 8'h00, 16'h0001);
		chk("verify match", 32'h0, r_data);
		chk("verify length", 32'd88, HM.n_last);
		chk("verify serial", 32'h99, HM.msg[79]);
		chk("verify extra", i_extra_message_bytes[39:32], HM.msg[76]);
		i_response_input = ~DIG;
		run(`OP_MAC_VERIFY, 8'h00, 16'h0001);
		chk("verify miss", 32'h1, r_data);
		// Derive corners: mode, nonce, authorization, parent source, use limit, input MAC.
		run(`OP_DERIVE, 8'h01, 16'h0002);
		chk("dk mode", 32'h3, r_data);
		run(`OP_DERIVE, 8'h04, 16'h0002);
		chk("dk flag", 32'hf, r_data);
		i_temp_valid = 1'b0;
		run(`OP_DERIVE, 8'h00, 16'h0002);
		chk("dk nonce", 32'hf, r_data);
		{i_temp_valid, i_nonce_source_flag, i_key_config_word[2]} = {2'h3, 16'h0340};
		run(`OP_DERIVE, 8'h04, 16'h0002);
		chk("dk random", 32'hf, r_data);
		{i_nonce_source_flag, i_key_config_word[2]} = {1'b0, 16'h0380};
		run(`OP_DERIVE, 8'h00, 16'h0002);
		chk("dk roll auth", 32'hf, r_data);
		{i_slot_config_word[7], i_slot_config_word[8]} = {16'h3200, 16'ha200};
		run(`OP_DERIVE, 8'h00, 16'h0007);
		chk("dk parent auth", 32'hf, r_data);
		{i_auth_valid, i_authorizing_key_index, i_slot_config_word[2]} = {5'h13, 16'h2020};
		load(21'h1fffff, 21'h0);
		run(`OP_DERIVE, 8'h00, 16'h0007);
		chk("dk use limit", 32'hf, r_data);
		load(21'h0, 21'h0);
		run(`OP_DERIVE, 8'h00, 16'h0007);
		chk("dk create", {1'b1, 4'h7, 8'h00}, {r_wr, r_wi, r_data[7:0]});
		chk("dk create src", {8'h02, 8'h07}, {HM.msg[0], HM.msg[34]});
		run(`OP_DERIVE, 8'h00, 16'h0008);
		chk("im refused", {8'h0f, 8'd39}, {r_data[7:0], HM.n_last[7:0]});
		chk("im message", {8'h02, 8'h08, 8'h99}, {HM.msg[0], HM.msg[34], HM.msg[36]});
		i_input_mac = DIG;
		run(`OP_DERIVE, 8'h00, 16'h0008);
		chk("im accepted", {1'b1, 4'h8, 8'h00, 8'h08, 8'd96},
			{r_wr, r_wi, r_data[7:0], HM.msg[0], HM.n_last[7:0]});
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
